//--- inc/dither_port_pkg.sv
// constants shared by the host and device ends of the dither serial port
// assumes both ends run on clk_in and meet through dither_link_if
package dither_port_pkg;
  localparam int          WORD_BITS     = 24;
  localparam int          CHANNELS      = 16;
  localparam int          CNT_W         = 5;
  localparam logic [3:0]  CMD_ROUTE_LO  = 4'h9;
  localparam logic [3:0]  CMD_ROUTE_HI  = 4'hA;
  localparam logic [3:0]  CMD_SCALE_LO  = 4'hC;
  localparam logic [3:0]  CMD_SCALE_HI  = 4'hD;
  localparam logic [3:0]  CMD_INVERT    = 4'hB;
  localparam logic [3:0]  CMD_SPAN      = 4'h4;
  localparam int          CMD_POS       = 20;
  localparam int          SPAN_W        = 3;
  localparam logic [1:0]  ROUTE_FIRST   = 2'h1;
  localparam logic [1:0]  ROUTE_SECOND  = 2'h2;
  localparam logic [1:0]  SCALE_NONE    = 2'h0;
  localparam logic [15:0] INVERT_RESET  = 16'h0000;
  localparam logic [31:0] ROUTE_RESET   = 32'h0000_0000;
  localparam logic [31:0] SCALE_RESET   = 32'h0000_0000;
  localparam int          SCLK_DIV      = 4;
  localparam int          DIV_W         = 3;
endpackage : dither_port_pkg

//--- inc/dither_link_if.sv
// four-wire serial link between host and device ends
// assumes one system clock; sclk is a plain sampled level
`timescale 1ns/1ns
`default_nettype none
interface dither_link_if;
  logic sclk;      // serial clock from host
  logic sdi;       // data into device
  logic sdo;       // data out of device
  logic sync_n;    // frame sync, active low
  modport host   (output sclk, output sdi, output sync_n, input sdo);
  modport device (input sclk, input sdi, input sync_n, output sdo);
endinterface : dither_link_if
`default_nettype wire

//--- core/dither_port_device.sv
// device end: shifts 24-bit frames and keeps dither routing state
// assumes link levels are synchronous to clk_in
`timescale 1ns/1ns
`default_nettype none
module dither_port_device (
  input  wire logic                               clk_in,
  input  wire logic                               sys_rst_in,
  dither_link_if.device                           link,
  input  wire logic                               dither_input_first_in,
  input  wire logic                               dither_input_second_in,
  output logic [dither_port_pkg::CHANNELS-1:0]    channel_dither_out,
  output logic [2*dither_port_pkg::CHANNELS-1:0]  channel_scale_out,
  output logic [dither_port_pkg::CHANNELS-1:0]    channel_invert_out,
  output logic [dither_port_pkg::CHANNELS-1:0]    channel_span_set_out,
  output logic                                    word_done_out
);
  import dither_port_pkg::*;

  // frame receiver states, one flip-flop each
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001, // sync released, waiting for a frame
    RX_SHIFT = 3'b010, // frame open, at most one word seen
    RX_OVER  = 3'b100  // frame ran past one word and is dropped
  } rx_state_t;

  // receiver state and bit count of the open frame
  rx_state_t             rx_state_reg;
  rx_state_t             rx_state_next;
  logic [CNT_W-1:0]      count_reg;
  logic [CNT_W-1:0]      count_next;

  // shift register and the last serial clock level
  logic [WORD_BITS-1:0]  shift_reg;
  logic                  sclk_reg;

  // settings kept until the next matching command; span bits are kept until reset
  logic [2*CHANNELS-1:0] route_reg;
  logic [2*CHANNELS-1:0] scale_reg;
  logic [CHANNELS-1:0]   invert_reg;
  logic [CHANNELS-1:0]   span_reg;

  // per-channel dither levels, next and registered
  logic [CHANNELS-1:0]   dither_reg;
  logic [CHANNELS-1:0]   dither_next;

  // one-hot mask of the channel named by a four-bit address
  function automatic logic [CHANNELS-1:0] chan_mask(input logic [3:0] addr);
    logic [CHANNELS-1:0] mask;
    mask       = '0;
    mask[addr] = 1'b1;
    return mask;
  endfunction : chan_mask

  // a channel carries a tone only for the two codes that name an input
  function automatic logic is_routed(input logic [1:0] sel);
    return (sel == ROUTE_FIRST) || (sel == ROUTE_SECOND);
  endfunction : is_routed

  // tone chosen by a channel's two routing bits; 00 and 11 give none
  function automatic logic pick_tone(input logic [1:0] sel,
                                     input logic       first,
                                     input logic       second);
    logic tone;
    tone = 1'b0;
    if (sel == ROUTE_FIRST) begin
      tone = first;
    end else if (sel == ROUTE_SECOND) begin
      tone = second;
    end
    return tone;
  endfunction : pick_tone

  // serial clock fall against last cycle's level, and frame qualifiers
  wire fall_edge = sclk_reg & ~link.sclk;
  wire in_frame  = (rx_state_reg == RX_SHIFT) & ~link.sync_n;
  wire shift_en  = in_frame & fall_edge;
  wire full_word = (count_reg == CNT_W'(WORD_BITS));

  // a word is taken only when a frame of exactly one word closes
  wire word_ok   = (rx_state_reg == RX_SHIFT) & link.sync_n & full_word;

  // command fields of the received word
  wire [3:0]          cmd       = shift_reg[WORD_BITS-1:CMD_POS];
  wire [3:0]          chan_addr = shift_reg[7:4];
  wire [CHANNELS-1:0] payload   = shift_reg[CHANNELS-1:0];

  // command decode; each strobe lasts the one cycle of word_ok
  wire hit_route_lo = word_ok & (cmd == CMD_ROUTE_LO);
  wire hit_route_hi = word_ok & (cmd == CMD_ROUTE_HI);
  wire hit_scale_lo = word_ok & (cmd == CMD_SCALE_LO);
  wire hit_scale_hi = word_ok & (cmd == CMD_SCALE_HI);
  wire hit_invert   = word_ok & (cmd == CMD_INVERT);
  wire hit_span     = word_ok & (cmd == CMD_SPAN);

  // data out shows the top of the shift register
  assign link.sdo = shift_reg[WORD_BITS-1];

  // next receiver state; a bit past one word marks the frame for dropping
  always_comb begin
    rx_state_next = rx_state_reg;
    count_next    = count_reg;
    case (rx_state_reg)
      RX_IDLE: begin
        count_next = '0;
        if (!link.sync_n) begin
          rx_state_next = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (link.sync_n) begin
          rx_state_next = RX_IDLE;
        end else if (fall_edge && full_word) begin
          rx_state_next = RX_OVER;
        end else if (fall_edge) begin
          count_next = count_reg + 5'h01;
        end
      end
      RX_OVER: begin
        if (link.sync_n) begin
          rx_state_next = RX_IDLE;
        end
      end
      default: begin
        rx_state_next = RX_IDLE;
      end
    endcase
  end

  // receiver registers; sclk resets high so no false fall follows reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_state_reg <= RX_IDLE;
      count_reg    <= '0;
      sclk_reg     <= 1'b1;
    end else begin
      rx_state_reg <= rx_state_next;
      count_reg    <= count_next;
      sclk_reg     <= link.sclk;
    end
  end

  // shift the data line in, most significant bit first
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      shift_reg <= '0;
    end else if (shift_en) begin
      shift_reg <= {shift_reg[WORD_BITS-2:0], link.sdi};
    end
  end

  // routing: low command covers channels 7..0, high command 15..8
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      route_reg <= ROUTE_RESET;
    end else if (hit_route_lo) begin
      route_reg[CHANNELS-1:0] <= payload;
    end else if (hit_route_hi) begin
      route_reg[2*CHANNELS-1:CHANNELS] <= payload;
    end
  end

  // scaling: same channel split as routing
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      scale_reg <= SCALE_RESET;
    end else if (hit_scale_lo) begin
      scale_reg[CHANNELS-1:0] <= payload;
    end else if (hit_scale_hi) begin
      scale_reg[2*CHANNELS-1:CHANNELS] <= payload;
    end
  end

  // inversion: one bit per channel, none after reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      invert_reg <= INVERT_RESET;
    end else if (hit_invert) begin
      invert_reg <= payload;
    end
  end

  // span write unclamps its channel; only reset clamps it again
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      span_reg <= '0;
    end else if (hit_span) begin
      span_reg <= span_reg | chan_mask(chan_addr);
    end
  end

  // one-cycle pulse after each accepted word
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      word_done_out <= 1'b0;
    end else begin
      word_done_out <= word_ok;
    end
  end

  // routed tone, inverted where asked, on span-set channels; unrouted or unspanned channels stay quiet
  always_comb begin
    dither_next = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      dither_next[i] = span_reg[i] & is_routed(route_reg[2*i +: 2]) &
                       (pick_tone(route_reg[2*i +: 2], dither_input_first_in,
                                  dither_input_second_in) ^ invert_reg[i]);
    end
  end

  // dither levels leave through flip-flops
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dither_reg <= '0;
    end else begin
      dither_reg <= dither_next;
    end
  end

  // scale, invert and span settings shown as kept; routing is not an output
  assign channel_dither_out   = dither_reg;
  assign channel_scale_out    = scale_reg;
  assign channel_invert_out   = invert_reg;
  assign channel_span_set_out = span_reg;
endmodule : dither_port_device
`default_nettype wire

//--- core/dither_port_host.sv
// host end: sends one 24-bit word per request as serial master
// assumes the caller orders scale, invert, span, then route commands
`timescale 1ns/1ns
`default_nettype none
module dither_port_host (
  input  wire logic                                clk_in,
  input  wire logic                                sys_rst_in,
  dither_link_if.host                              link,
  input  wire logic                                cmd_valid_in,
  input  wire logic [dither_port_pkg::WORD_BITS-1:0] cmd_word_in,
  output logic                                     cmd_ready_out,
  output logic                                     cmd_done_out
);
  import dither_port_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_END  = 3'b100
  } host_state_t;

  host_state_t           state_reg;
  logic [WORD_BITS-1:0]  word_reg;
  logic [CNT_W-1:0]      bits_reg;
  logic [DIV_W-1:0]      div_reg;

  // half-period enable from divider
  wire tick = (div_reg == DIV_W'(SCLK_DIV - 1));

  assign cmd_ready_out = (state_reg == ST_IDLE);

  // frame sequencer; data changes on rising edge, held over falling
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg    <= ST_IDLE;
      word_reg     <= '0;
      bits_reg     <= '0;
      div_reg      <= '0;
      link.sclk    <= 1'b1;
      link.sdi     <= 1'b0;
      link.sync_n  <= 1'b1;
      cmd_done_out <= 1'b0;
    end else begin
      cmd_done_out <= 1'b0;
      div_reg <= tick ? '0 : div_reg + 3'h1;
      case (state_reg)
        ST_IDLE: begin
          div_reg <= '0;
          if (cmd_valid_in) begin
            word_reg    <= cmd_word_in << 1;
            link.sdi    <= cmd_word_in[WORD_BITS-1];
            link.sync_n <= 1'b0;
            bits_reg    <= '0;
            state_reg   <= ST_SHIFT;
          end
        end
        ST_SHIFT: if (tick) begin
          link.sclk <= ~link.sclk;
          if (link.sclk) begin
            bits_reg <= bits_reg + 5'h01; // falling edge samples bit
          end else if (bits_reg == CNT_W'(WORD_BITS)) begin
            state_reg <= ST_END;
          end else begin
            link.sdi <= word_reg[WORD_BITS-1];
            word_reg <= word_reg << 1;
          end
        end
        ST_END: if (tick) begin
          link.sync_n  <= 1'b1;
          cmd_done_out <= 1'b1;
          state_reg    <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule : dither_port_host
`default_nettype wire

//--- test/dither_config_serial_port_checker.sv
// link checker for the dither serial port, fed from the interface signals
// assumes one clock; sclk and sync_n are levels sampled on clk_in
`timescale 1ns/1ns
`default_nettype none
module dither_config_serial_port_checker (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sync_n
);
  logic [5:0] falls;
  // counts serial clock falls inside one frame
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || sync_n) falls <= 6'h00;
    else if ($fell(sclk)) falls <= falls + 6'h01;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence low_half;
    !sclk [*4];
  endsequence
  a_sclk_idle_high: assert property (sync_n |-> sclk)
    else $error("sclk low outside a frame");
  a_start_clk_high: assert property ($fell(sync_n) |-> sclk)
    else $error("frame opened with sclk low");
  a_sdi_held_fall: assert property ($fell(sclk) |-> $stable(sdi))
    else $error("sdi moved at sclk fall");
  a_sclk_low_half: assert property ($fell(sclk) |-> low_half ##1 sclk)
    else $error("sclk low phase not four cycles");
  a_fall_in_frame: assert property ($fell(sclk) |-> !sync_n)
    else $error("sclk fall outside a frame");
  a_word_24_bits: assert property ($rose(sync_n) |-> falls == 6'h18)
    else $error("frame not 24 bits");
  a_frame_bounded: assert property ($fell(sync_n) |-> ##[24:400] sync_n)
    else $error("frame never closed");
  a_idle_gap: assert property ($rose(sync_n) |=> sync_n)
    else $error("no idle cycle between frames");
  a_sdo_quiet_idle: assert property (sync_n && $past(sync_n) |-> $stable(sdo))
    else $error("sdo moved outside a frame");
endmodule : dither_config_serial_port_checker
`default_nettype wire

//--- test/tb_dither_config_serial_port.sv
// bench: host end drives device end; a bench model tracks the settings
// assumes package constants and one 10 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb_dither_config_serial_port;
  import dither_port_pkg::*;
  logic        clk_in = 0, sys_rst_in = 1, cmd_valid_in = 0, ready, done, wdone;
  logic        n0 = 0, n1 = 0;
  logic [23:0] cmd_word_in = 24'h000000, w;
  logic [15:0] dith, inv, span, m_inv = 16'h0000, m_span = 16'h0000;
  logic [31:0] scale, m_route = 32'h00000000, m_scale = 32'h00000000;
  logic [31:0] lfsr = 32'hC337AB8D;
  logic [3:0]  ops [6] = '{CMD_SCALE_LO, CMD_SCALE_HI, CMD_INVERT, CMD_SPAN,
                           CMD_ROUTE_LO, CMD_ROUTE_HI};
  int          error_cnt = 0, num_checks = 0;
  always #50 clk_in = ~clk_in;
  dither_link_if link ();
  dither_port_host dither_port_host_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .link(link), .cmd_valid_in(cmd_valid_in), .cmd_word_in(cmd_word_in),
    .cmd_ready_out(ready), .cmd_done_out(done));
  dither_port_device dither_port_device_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .link(link), .dither_input_first_in(n0), .dither_input_second_in(n1),
    .channel_dither_out(dith), .channel_scale_out(scale), .channel_invert_out(inv),
    .channel_span_set_out(span), .word_done_out(wdone));
  dither_config_serial_port_checker chk_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo), .sync_n(link.sync_n));
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(logic [31:0] g, logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // one command word through the host, then wait for the device to take it
  task automatic send(logic [23:0] x);
    logic seen;
    seen = 1'b0;
    @(negedge clk_in);
    cmd_word_in = x;
    cmd_valid_in = 1'b1;
    while (ready !== 1'b1) @(negedge clk_in);
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    repeat (400) begin
      @(negedge clk_in);
      if (done === 1'b1) seen = 1'b1;
      if (wdone === 1'b1) break;
    end
    chk(wdone, 1);
    chk(seen, 1);
    chk(link.sdo, x[23]);
  endtask : send
  // watchdog: twice the expected run length
  initial begin
    #(100 * 40 * 400);
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge clk_in);
    @(negedge clk_in) sys_rst_in = 1'b0;
    chk(scale, SCALE_RESET);
    chk(inv, INVERT_RESET);
    for (int i = 0; i < 40; i++) begin
      lfsr = nxt(lfsr);
      w = lfsr[23:0];
      if (i < 12 || lfsr[31]) w[23:20] = ops[(i < 12) ? i % 6 : lfsr[26:24] % 6];
      send(w);
      case (w[23:20])
        CMD_ROUTE_LO: m_route[15:0] = w[15:0];
        CMD_ROUTE_HI: m_route[31:16] = w[15:0];
        CMD_SCALE_LO: m_scale[15:0] = w[15:0];
        CMD_SCALE_HI: m_scale[31:16] = w[15:0];
        CMD_INVERT:   m_inv = w[15:0];
        CMD_SPAN:     m_span[w[7:4]] = 1'b1;
        default:      ;
      endcase
      @(negedge clk_in);
      n0 = lfsr[5];
      n1 = lfsr[9];
      @(negedge clk_in); // registered dither needs one edge to follow n0 and n1
      chk(scale, m_scale);
      chk(inv, m_inv);
      chk(span, m_span);
      for (int c = 0; c < CHANNELS; c++) begin
        if (!m_span[c]) chk(dith[c], 0);
        else if (m_route[2*c+:2] == ROUTE_FIRST) chk(dith[c], n0 ^ m_inv[c]);
        else if (m_route[2*c+:2] == ROUTE_SECOND) chk(dith[c], n1 ^ m_inv[c]);
        else chk(dith[c], 0);
      end
      $display("test %0d done", i);
    end
    test_done;
  end
endmodule : tb_dither_config_serial_port
`default_nettype wire
